/* File: verilog/aisl_regs.vh */
/*
  Register indices, field positions, reset values, alarm codes and timing
  constants for the alarm and information status block.
  Assumes a 32-bit AHB-Lite register bus; byte address = 4 * register index.
*/
`ifndef AISL_REGS_VH
`define AISL_REGS_VH

// Register indices (byte address is four times the index)
`define AISL_IDX_OVL_ALM_TH    18'h00180
`define AISL_IDX_DEV_ALM_TH    18'h00181
`define AISL_IDX_DRV_TMP_TH    18'h001a0
`define AISL_IDX_OVL_TIME_TH   18'h001a1
`define AISL_IDX_SPEED_TH      18'h001a2
`define AISL_IDX_DEV_INFO_TH   18'h001a5
`define AISL_IDX_MTR_TMP_TH    18'h001a8
`define AISL_IDX_OVOLT_TH      18'h001ab
`define AISL_IDX_USR_SEL       18'h001bc
`define AISL_IDX_USR_INV       18'h001bd
`define AISL_IDX_LED_EN        18'h001be
`define AISL_IDX_AUTO_CLR      18'h001bf
`define AISL_IDX_INFO_ACT      18'h007c0
`define AISL_IDX_STATUS        18'h007d0
`define AISL_IDX_INFO_CLR      18'h007d1
`define AISL_IDX_BUS_ERR_EN    18'h06188

// Reset values
`define AISL_RST_OVL_ALM_TH    32'h00000032
`define AISL_RST_DEV_ALM_TH    32'h0000012c
`define AISL_RST_DRV_TMP_TH    32'h00000055
`define AISL_RST_OVL_TIME_TH   32'h00000032
`define AISL_RST_SPEED_TH      32'h00000000
`define AISL_RST_DEV_INFO_TH   32'h0000012c
`define AISL_RST_MTR_TMP_TH    32'h00000055
`define AISL_RST_OVOLT_TH      32'h00000276
`define AISL_RST_USR_SEL       8'h80
`define AISL_RST_USR_INV       1'b0
`define AISL_RST_LED_EN        1'b1
`define AISL_RST_AUTO_CLR      1'b1
`define AISL_RST_BUS_ERR_EN    1'b1
`define AISL_RST_INFO_ACT      6'h3f

// Number of signals the user-assigned output can select
`define AISL_USR_NSRC          8'h10

// Alarm codes
`define AISL_CODE_NONE         8'h00
`define AISL_CODE_WRAP         8'h72
`define AISL_CODE_BUS          8'h81
`define AISL_CODE_NETMOD       8'h82
`define AISL_CODE_OVERLOAD     8'h30
`define AISL_CODE_DEVIATION    8'h10

// Status register field positions
`define AISL_ST_CODE_LSB       0
`define AISL_ST_ACTIVE         8
`define AISL_ST_EXCITE         9
`define AISL_ST_INFO_LSB       16
`define AISL_ST_SUMMARY        22

// Timing: clock rate and LED blink half period
`define AISL_CLK_KHZ           100000
`define AISL_BLINK_HALF_MS     250

`endif

/* File: verilog/aisl_top.v */
/*
  Alarm and information status logic of a stepper driver: alarm raising,
  excitation handling, alarm clear handshake, information bits, summary,
  user-assigned output and LED, with an AHB-Lite register slave.
  Reads take one wait state; writes complete without waits.
  Fatal codes (wrap setting, network module) are cleared only by hresetn.
  Information bits follow or latch their cause as auto clear selects.
  Assumes one 100 MHz clock; measurements and fault flags come from logic
  on the same clock; alarm_clear_in and run_cmd_in are asynchronous pins.
  Measurements arrive unsigned, already scaled to threshold units.
*/
// The AHB-Lite interface to the registers was decided locally.
// Contract
// - Wrap setting mismatch at power-up raises 72h, cuts current, needs power cycle.
// - Lost host link raises 81h, current kept, any reset operation clears.
// - Network module fault raises 82h, current cut, cleared by power cycle only.
// - Non-excitation alarm cuts motor current and leaves the brake engaged.
// - Excitation alarm keeps current on and holds the present position.
// - Bus error alarm enabled by a setting, 1 enables, default 1.
// - Overload alarm at configurable threshold in 0.1 s units, default 50.
// - Deviation alarm when deviation exceeds threshold in 0.01 rev, default 300.
// - Any alarm drops alarm status and motion outputs and stops the motor.
// - Clear input with cause gone clears alarm, raises status and ready.
// - Each information condition asserts its own information bit output.
// - User-assigned output follows one selected internal signal.
// - Any reflected information condition asserts the summary output.
// - A reflected information condition makes the LED blink blue.
// - Information conditions never stop or de-energise the motor.
// - Action setting 0 asserts only the bit, summary and LED unchanged.
// - Driver temperature information at configurable threshold, default 85.
// - Motor temperature information at configurable threshold, default 85.
// - Speed information disabled at threshold 0, default 0.
// - Deviation information at configurable threshold, default 300.
// - With auto clear on, bits and summary drop when cause disappears.
`timescale 1ns/1ps
`include "aisl_regs.vh"

module aisl_top #(
  parameter BLINK_HALF_CYC = `AISL_BLINK_HALF_MS * `AISL_CLK_KHZ,
  parameter NINFO          = 6
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        alarm_clear_in,
  input  wire        run_cmd_in,
  input  wire        wrap_mismatch,
  input  wire        host_link_lost,
  input  wire        net_module_fault,
  input  wire [31:0] overload_time,
  input  wire [31:0] position_deviation,
  input  wire [31:0] driver_temp,
  input  wire [31:0] motor_temp,
  input  wire [31:0] motor_speed,
  input  wire [31:0] bus_voltage,
  output reg         alarm_status_out,
  output reg         motion_active_out,
  output reg         ready_out,
  output reg         motor_current_en,
  output reg         motor_stop,
  output reg         brake_release,
  output reg  [7:0]  alarm_code,
  output reg  [5:0]  info_bits_out,
  output reg         info_summary_out,
  output reg         user_assigned_info_out,
  output reg         power_fault_led_blue,
  output reg         power_fault_led_red
);

  // Register storage
  reg [31:0] ovl_alm_th;
  reg [31:0] dev_alm_th;
  reg [31:0] drv_tmp_th;
  reg [31:0] ovl_time_th;
  reg [31:0] speed_th;
  reg [31:0] dev_info_th;
  reg [31:0] mtr_tmp_th;
  reg [31:0] ovolt_th;
  reg [7:0]  usr_sel;
  reg        usr_inv;
  reg        led_en;
  reg        auto_clr;
  reg [5:0]  info_act;
  reg        bus_err_en;

  // Bus state
  reg        wr_pend;
  reg        rd_pend;
  reg [17:0] bus_idx;
  reg [5:0]  info_clr_req;

  // Pin synchronisers and alarm state
  reg [1:0]  sync_a;
  reg [1:0]  sync_b;
  reg        por_done;
  reg        alarm_active;
  reg        alarm_excite;
  reg [5:0]  info_bits;
  reg [31:0] blink_cnt;
  reg        blink_phase;

  // Synchronised pins and address-phase decode
  wire       clear_req = sync_b[0];
  wire       run_cmd   = sync_b[1];
  wire       addr_ok   = hsel & htrans[1] & hready;
  wire       wr_en     = wr_pend;

  // Alarm causes
  // Overload trips at the threshold, deviation only above it
  wire       cause_bus  = host_link_lost & bus_err_en;
  wire       cause_ovl  = overload_time >= ovl_alm_th;
  wire       cause_dev  = position_deviation > dev_alm_th;
  wire       cause_wrap = ~por_done & wrap_mismatch;
  wire       clearable  = (alarm_code != `AISL_CODE_WRAP) && (alarm_code != `AISL_CODE_NETMOD);
  wire       cause_any  = cause_bus | cause_ovl | cause_dev | net_module_fault;

  // Information conditions, one bit per condition
  wire [5:0] info_cond;
  assign info_cond[0] = driver_temp >= drv_tmp_th;
  assign info_cond[1] = overload_time >= ovl_time_th;
  assign info_cond[2] = (speed_th != 32'h0) & (motor_speed >= speed_th);
  assign info_cond[3] = position_deviation >= dev_info_th;
  assign info_cond[4] = motor_temp >= mtr_tmp_th;
  assign info_cond[5] = bus_voltage >= ovolt_th;

  wire       summary = |(info_bits & info_act);

  // Signals the user-assigned output can follow; select above range reads 0
  // Index 6 is a constant low, matching the const-off default
  wire [15:0] usr_src = {5'h00, summary, ready_out, motion_active_out,
                         alarm_status_out, 1'b0, info_bits[5:0]};
  wire        usr_hit = (usr_sel < `AISL_USR_NSRC) ? usr_src[usr_sel[3:0]] : 1'b0;

  // Status word for software, assembled field by field
  reg  [31:0] status_word;
  always @* begin
    status_word                         = 32'h0;
    status_word[`AISL_ST_CODE_LSB +: 8] = alarm_code;
    status_word[`AISL_ST_ACTIVE]        = alarm_active;
    status_word[`AISL_ST_EXCITE]        = alarm_excite;
    status_word[`AISL_ST_INFO_LSB +: 6] = info_bits;
    status_word[`AISL_ST_SUMMARY]       = summary;
  end

  // Synchronise the asynchronous pins through two flip-flops
  // Bit 0 carries the clear pin, bit 1 the run command
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= {run_cmd_in, alarm_clear_in};
      sync_b <= sync_a;
    end
  end

  // AHB-Lite slave: writes finish with zero wait, reads take one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      bus_idx   <= 18'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      hresp <= 1'b0;
      // Second cycle of a read: drive the data and release the wait
      if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= rd_mux(bus_idx);
      end else begin
        // Address phase: a write is remembered for its data phase
        wr_pend <= addr_ok & hwrite;
        if (addr_ok) begin
          bus_idx <= haddr[19:2];
        end
        if (addr_ok & ~hwrite) begin
          rd_pend   <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // Read multiplexer; unmapped indices read zero
  // Narrow fields are zero-extended to the word
  function [31:0] rd_mux;
    input [17:0] idx;
    begin
      case (idx)
        `AISL_IDX_OVL_ALM_TH:  rd_mux = ovl_alm_th;
        `AISL_IDX_DEV_ALM_TH:  rd_mux = dev_alm_th;
        `AISL_IDX_DRV_TMP_TH:  rd_mux = drv_tmp_th;
        `AISL_IDX_OVL_TIME_TH: rd_mux = ovl_time_th;
        `AISL_IDX_SPEED_TH:    rd_mux = speed_th;
        `AISL_IDX_DEV_INFO_TH: rd_mux = dev_info_th;
        `AISL_IDX_MTR_TMP_TH:  rd_mux = mtr_tmp_th;
        `AISL_IDX_OVOLT_TH:    rd_mux = ovolt_th;
        `AISL_IDX_USR_SEL:     rd_mux = {24'h0, usr_sel};
        `AISL_IDX_USR_INV:     rd_mux = {31'h0, usr_inv};
        `AISL_IDX_LED_EN:      rd_mux = {31'h0, led_en};
        `AISL_IDX_AUTO_CLR:    rd_mux = {31'h0, auto_clr};
        `AISL_IDX_INFO_ACT:    rd_mux = {26'h0, info_act};
        `AISL_IDX_STATUS:      rd_mux = status_word;
        `AISL_IDX_BUS_ERR_EN:  rd_mux = {31'h0, bus_err_en};
        default:               rd_mux = 32'h0;
      endcase
    end
  endfunction

  // Register writes in the data phase
  // The info clear is a one-cycle strobe, so a held value never
  // clears a bit that is raised again later
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovl_alm_th   <= `AISL_RST_OVL_ALM_TH;
      dev_alm_th   <= `AISL_RST_DEV_ALM_TH;
      drv_tmp_th   <= `AISL_RST_DRV_TMP_TH;
      ovl_time_th  <= `AISL_RST_OVL_TIME_TH;
      speed_th     <= `AISL_RST_SPEED_TH;
      dev_info_th  <= `AISL_RST_DEV_INFO_TH;
      mtr_tmp_th   <= `AISL_RST_MTR_TMP_TH;
      ovolt_th     <= `AISL_RST_OVOLT_TH;
      usr_sel      <= `AISL_RST_USR_SEL;
      usr_inv      <= `AISL_RST_USR_INV;
      led_en       <= `AISL_RST_LED_EN;
      auto_clr     <= `AISL_RST_AUTO_CLR;
      info_act     <= `AISL_RST_INFO_ACT;
      bus_err_en   <= `AISL_RST_BUS_ERR_EN;
      info_clr_req <= 6'h00;
    end else begin
      info_clr_req <= 6'h00;
      if (wr_en) begin
        case (bus_idx)
          `AISL_IDX_OVL_ALM_TH:  ovl_alm_th  <= hwdata;
          `AISL_IDX_DEV_ALM_TH:  dev_alm_th  <= hwdata;
          `AISL_IDX_DRV_TMP_TH:  drv_tmp_th  <= hwdata;
          `AISL_IDX_OVL_TIME_TH: ovl_time_th <= hwdata;
          `AISL_IDX_SPEED_TH:    speed_th    <= hwdata;
          `AISL_IDX_DEV_INFO_TH: dev_info_th <= hwdata;
          `AISL_IDX_MTR_TMP_TH:  mtr_tmp_th  <= hwdata;
          `AISL_IDX_OVOLT_TH:    ovolt_th    <= hwdata;
          `AISL_IDX_USR_SEL:     usr_sel     <= hwdata[7:0];
          `AISL_IDX_USR_INV:     usr_inv     <= hwdata[0];
          `AISL_IDX_LED_EN:      led_en      <= hwdata[0];
          `AISL_IDX_AUTO_CLR:    auto_clr    <= hwdata[0];
          `AISL_IDX_INFO_ACT:    info_act    <= hwdata[5:0];
          `AISL_IDX_INFO_CLR:    info_clr_req <= hwdata[5:0];
          `AISL_IDX_BUS_ERR_EN:  bus_err_en  <= hwdata[0];
          default:               info_clr_req <= 6'h00;
        endcase
      end
    end
  end

  // Alarm capture: power-up check, priority of causes, clear handshake
  // Fatal codes may replace an excitation alarm; any other cause
  // keeps the first code so software sees what tripped first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_done     <= 1'b0;
      alarm_active <= 1'b0;
      alarm_excite <= 1'b1;
      alarm_code   <= `AISL_CODE_NONE;
    end else begin
      por_done <= 1'b1;
      if (cause_wrap) begin
        alarm_active <= 1'b1;
        alarm_excite <= 1'b0;
        alarm_code   <= `AISL_CODE_WRAP;
      end else if (net_module_fault && (!alarm_active || alarm_excite)) begin
        alarm_active <= 1'b1;
        alarm_excite <= 1'b0;
        alarm_code   <= `AISL_CODE_NETMOD;
      end else if (!alarm_active && cause_bus) begin
        alarm_active <= 1'b1;
        alarm_excite <= 1'b1;
        alarm_code   <= `AISL_CODE_BUS;
      end else if (!alarm_active && cause_ovl) begin
        alarm_active <= 1'b1;
        alarm_excite <= 1'b1;
        alarm_code   <= `AISL_CODE_OVERLOAD;
      end else if (!alarm_active && cause_dev) begin
        alarm_active <= 1'b1;
        alarm_excite <= 1'b1;
        alarm_code   <= `AISL_CODE_DEVIATION;
      end else if (alarm_active && clear_req && clearable && !cause_any) begin
        alarm_active <= 1'b0;
        alarm_excite <= 1'b1;
        alarm_code   <= `AISL_CODE_NONE;
      end
    end
  end

  // Information bit per condition: set wins, auto clear or software clear
  // A same-cycle condition beats a clear so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < NINFO; gi = gi + 1) begin : g_info
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          info_bits[gi] <= 1'b0;
        end else if (info_cond[gi]) begin
          info_bits[gi] <= 1'b1;
        end else if (auto_clr || info_clr_req[gi]) begin
          info_bits[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Blink timer for the indicator LED
  // Free-running; the LED output gates it, so no start handshake
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF_CYC - 1) begin
      blink_cnt   <= 32'h0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // Registered outputs; information never touches motion or current
  // Excitation alarms keep current and the brake released; fatal ones
  // cut current and let the brake hold the shaft
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_status_out       <= 1'b0;
      motion_active_out      <= 1'b0;
      ready_out              <= 1'b0;
      motor_current_en       <= 1'b0;
      motor_stop             <= 1'b1;
      brake_release          <= 1'b0;
      info_bits_out          <= 6'h00;
      info_summary_out       <= 1'b0;
      user_assigned_info_out <= 1'b0;
      power_fault_led_blue   <= 1'b0;
      power_fault_led_red    <= 1'b0;
    end else begin
      alarm_status_out       <= ~alarm_active;
      motion_active_out      <= ~alarm_active & run_cmd;
      ready_out              <= ~alarm_active;
      motor_stop             <= alarm_active;
      motor_current_en       <= ~alarm_active | alarm_excite;
      brake_release          <= ~alarm_active | alarm_excite;
      info_bits_out          <= info_bits;
      info_summary_out       <= summary;
      user_assigned_info_out <= usr_hit ^ usr_inv;
      power_fault_led_blue   <= summary & led_en & blink_phase;
      power_fault_led_red    <= alarm_active;
    end
  end

endmodule

/* File: tb/aisl_checker.sv */
/* Assertions on the alarm and information outputs of aisl_top.
   Assumes a bind from the bench; one clock, reset active low. */
`timescale 1ns/1ps
module aisl_checker (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       alarm_clear_in,
  input wire logic       alarm_status_out,
  input wire logic       motion_active_out,
  input wire logic       ready_out,
  input wire logic       motor_current_en,
  input wire logic       motor_stop,
  input wire logic       brake_release,
  input wire logic [7:0] alarm_code,
  input wire logic [5:0] info_bits_out,
  input wire logic       info_summary_out
);
  logic [1:0] up;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles since reset release, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  AST_ALM_DROP: assert property (alarm_code != 8'h00 |=>
    !alarm_status_out && !motion_active_out && motor_stop) else $error("alarm outputs stay up");
  AST_NO_CURRENT: assert property ((alarm_code == 8'h72 || alarm_code == 8'h82) |=>
    !motor_current_en && !brake_release) else $error("current kept on fatal alarm");
  AST_KEEP_CURRENT: assert property ((alarm_code == 8'h81 || alarm_code == 8'h30 ||
    alarm_code == 8'h10) |=> motor_current_en && brake_release) else $error("current cut");
  AST_CLEAR_UP: assert property ((alarm_code != 8'h00) ##1 (alarm_code == 8'h00) |=>
    alarm_status_out && ready_out) else $error("status not raised after clear");
  AST_FATAL_HOLD: assert property ((alarm_code == 8'h72 || alarm_code == 8'h82) |=>
    $stable(alarm_code)) else $error("fatal alarm code changed");
  AST_CODE_HOLD: assert property (alarm_code != 8'h00 && !alarm_clear_in &&
    !$past(alarm_clear_in) && !$past(alarm_clear_in, 2) |=> alarm_code != 8'h00)
    else $error("alarm code lost without clear");
  AST_SUMMARY: assert property (info_summary_out |-> info_bits_out != 6'h00)
    else $error("summary without bit");
  AST_RUN_ON: assert property (up == 2'h3 && alarm_code == 8'h00 |=>
    !motor_stop && motor_current_en && ready_out) else $error("motor stopped without alarm");
endmodule

/* File: tb/aisl_host.sv */
/* Host controller model: run command and alarm clear handshake.
   Assumes the bench changes run_req and clr_req after clock edges. */
`timescale 1ns/1ps
module aisl_host (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run_req,
  input  wire logic clr_req,
  input  wire logic alarm_status_out,
  output logic      alarm_clear_in,
  output logic      run_cmd_in,
  output logic      clr_done
);
  // Run off first, then clear held until alarm status is seen high
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_clear_in <= 1'b0;
      run_cmd_in     <= 1'b0;
      clr_done       <= 1'b0;
    end else begin
      clr_done <= 1'b0;
      if (!clr_req) begin
        alarm_clear_in <= 1'b0;
        run_cmd_in     <= run_req;
      end else if (run_cmd_in)
        run_cmd_in <= 1'b0;
      else if (!alarm_clear_in)
        alarm_clear_in <= 1'b1;
      else if (alarm_status_out) begin
        alarm_clear_in <= 1'b0;
        clr_done       <= 1'b1;
      end
    end
  end
endmodule

/* File: tb/alarm_and_info_status_logic_test.sv */
/* Bench for aisl_top: AHB-Lite tasks, random thresholds and levels,
   alarms cleared through aisl_host. Assumes single slave on the bus. */
`timescale 1ns/1ps
module alarm_and_info_status_logic_test;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
  logic        wrap = 1'b0, link = 1'b0, netf = 1'b0, run_req = 1'b0, clr_req = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, t;
  logic [31:0] meas [6] = '{default: 32'h0};
  logic [31:0] th [6];
  logic [5:0]  act;
  int          err_total = 0, n_tests = 0, tog;
  int          lo [6] = '{40, 1, 0, 1, 40, 140};
  int          hi [6] = '{85, 290, 12000, 29990, 120, 630};
  logic [17:0] tix [6] = '{18'h1a0, 18'h1a1, 18'h1a2, 18'h1a5, 18'h1a8, 18'h1ab};
  logic [17:0] rix [9] = '{18'h180, 18'h181, 18'h1a0, 18'h1a1, 18'h1a2, 18'h1a5, 18'h1a8,
                           18'h1ab, 18'h6188};
  logic [31:0] rrs [9] = '{32'h32, 32'h12c, 32'h55, 32'h32, 32'h0, 32'h12c, 32'h55, 32'h276,
                           32'h1};
  wire         hreadyout, hresp, clr_in, run_in, clr_done, st, mv, rdy, cur, stp, brk;
  wire         summ, usr, blue, red;
  wire [31:0]  hrdata;
  wire [7:0]   code;
  wire [5:0]   bits;

  aisl_top #(.BLINK_HALF_CYC(4)) i_aisl_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .alarm_clear_in(clr_in), .run_cmd_in(run_in), .wrap_mismatch(wrap),
    .host_link_lost(link), .net_module_fault(netf), .overload_time(meas[1]),
    .position_deviation(meas[3]), .driver_temp(meas[0]), .motor_temp(meas[4]),
    .motor_speed(meas[2]), .bus_voltage(meas[5]), .alarm_status_out(st),
    .motion_active_out(mv), .ready_out(rdy), .motor_current_en(cur), .motor_stop(stp),
    .brake_release(brk), .alarm_code(code), .info_bits_out(bits), .info_summary_out(summ),
    .user_assigned_info_out(usr), .power_fault_led_blue(blue), .power_fault_led_red(red));
  aisl_host i_aisl_host (.hclk(hclk), .hresetn(hresetn), .run_req(run_req),
    .clr_req(clr_req), .alarm_status_out(st), .alarm_clear_in(clr_in),
    .run_cmd_in(run_in), .clr_done(clr_done));

  // Free-running 100 MHz clock
  always #5 hclk = ~hclk;

  function automatic logic [5:0] exp_info();
    for (int i = 0; i < 6; i++)
      exp_info[i] = meas[i] >= th[i] && !(i == 2 && th[i] == 32'h0);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge hclk);
  endtask

  // Count LED-on samples over 20 cycles
  task automatic count_blue();
    tog = 0;
    repeat (20) begin
      wt(1);
      tog += blue;
    end
  endtask

  // Wait for hready high, then end at the edge that samples it
  task automatic hold_rdy();
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    rd = hrdata;
    if (k >= 40) begin
      err_total++;
      finish_test();
    end
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [17:0] ix, input logic [31:0] wd);
    @(posedge hclk);
    haddr  <= {12'h000, ix, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    hold_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    hold_rdy();
  endtask

  task automatic do_reset(input logic wm);
    @(posedge hclk);
    hresetn <= 1'b0;
    wrap    <= wm;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wt(4);
  endtask

  task automatic clear_alarm(input logic ok);
    int k;
    @(posedge hclk);
    clr_req <= 1'b1;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (clr_done !== 1'b1 && k < 30);
    chk("clear accepted", ok, k < 30);
    @(posedge hclk);
    clr_req <= 1'b0;
    wt(3);
  endtask

  initial begin
    void'($urandom(71));
    do_reset(1'b0);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, rix[i], 32'h0);
      chk("reset value", rrs[i], rd);
    end
    bus(1'b0, 18'h3ff, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 18'h180, 32'd300);
    bus(1'b1, 18'h181, 32'd30000);
    @(posedge hclk);
    run_req <= 1'b1;
    // Random thresholds with levels just below, at and above them
    repeat (10) begin
      act = 6'($urandom);
      bus(1'b1, 18'h7c0, {26'h0, act});
      for (int i = 0; i < 6; i++) begin
        th[i] = 32'(lo[i]) + 32'($urandom % (hi[i] - lo[i] + 1));
        bus(1'b1, tix[i], th[i]);
      end
      @(posedge hclk);
      for (int i = 0; i < 6; i++)
        meas[i] <= th[i] + 32'($urandom % 3) - 32'h1;
      wt(3);
      chk("info bits", exp_info(), bits);
      chk("summary", |(exp_info() & act), summ);
      chk("motion", 1, mv);
    end
    bus(1'b1, 18'h7c0, 32'h3f);
    bus(1'b1, 18'h1bc, 32'h0);
    @(posedge hclk);
    meas[0] <= 32'd200;
    wt(3);
    chk("user out", 1, usr);
    bus(1'b1, 18'h1bd, 32'h1);
    wt(3);
    chk("user inverted", 0, usr);
    bus(1'b1, 18'h1bd, 32'h0);
    count_blue();
    chk("led blinks", 1, tog > 0 && tog < 20);
    bus(1'b1, 18'h1be, 32'h0);
    wt(3);
    count_blue();
    chk("led disabled", 0, tog);
    bus(1'b1, 18'h1be, 32'h1);
    bus(1'b1, 18'h7c0, 32'h0);
    wt(3);
    count_blue();
    chk("led masked", 0, tog);
    chk("summary masked", 0, summ);
    // Auto clear off: the bit latches until software clears it
    bus(1'b1, 18'h1bf, 32'h0);
    @(posedge hclk);
    meas[0] <= 32'h0;
    wt(3);
    chk("bit held", 1, bits[0]);
    bus(1'b1, 18'h7d1, 32'h1);
    wt(3);
    chk("bit cleared", 0, bits[0]);
    bus(1'b1, 18'h1bf, 32'h1);
    @(posedge hclk);
    for (int i = 0; i < 6; i++)
      meas[i] <= 32'h0;
    // Bus error alarm, disabled then enabled
    bus(1'b1, 18'h6188, 32'h0);
    link <= 1'b1;
    wt(4);
    chk("bus alarm off", 8'h00, code);
    bus(1'b1, 18'h6188, 32'h1);
    wt(4);
    chk("bus alarm", 8'h81, code);
    chk("current kept", 1, cur);
    chk("motion off", 0, mv);
    chk("stop and red", 2'h3, {stp, red});
    bus(1'b0, 18'h7d0, 32'h0);
    chk("status code", 8'h81, rd[7:0]);
    chk("response okay", 0, hresp);
    clear_alarm(1'b0);
    link <= 1'b0;
    clear_alarm(1'b1);
    chk("ready", 1, rdy & st);
    // Overload at threshold, deviation above threshold
    for (int s = 0; s < 2; s++) begin
      t = 32'h1 + 32'($urandom % (s ? 30000 : 300));
      bus(1'b1, s ? 18'h181 : 18'h180, t);
      @(posedge hclk);
      meas[s ? 3 : 1] <= t + 32'(s) - 32'h1;
      wt(4);
      chk("below limit", 8'h00, code);
      @(posedge hclk);
      meas[s ? 3 : 1] <= t + 32'(s);
      wt(4);
      chk("limit alarm", s ? 8'h10 : 8'h30, code);
      @(posedge hclk);
      meas[s ? 3 : 1] <= 32'h0;
      clear_alarm(1'b1);
    end
    @(posedge hclk);
    netf <= 1'b1;
    wt(4);
    chk("module alarm", 8'h82, code);
    chk("current cut", 0, cur | brk);
    netf <= 1'b0;
    clear_alarm(1'b0);
    chk("module kept", 8'h82, code);
    do_reset(1'b1);
    chk("wrap alarm", 8'h72, code);
    chk("wrap cut", 0, cur);
    wrap <= 1'b0;
    clear_alarm(1'b0);
    do_reset(1'b0);
    chk("power cycle", 8'h00, code);
    finish_test();
  end
endmodule

bind aisl_top aisl_checker i_aisl_checker (.hclk(hclk), .hresetn(hresetn),
  .alarm_clear_in(alarm_clear_in), .alarm_status_out(alarm_status_out),
  .motion_active_out(motion_active_out), .ready_out(ready_out),
  .motor_current_en(motor_current_en), .motor_stop(motor_stop),
  .brake_release(brake_release), .alarm_code(alarm_code), .info_bits_out(info_bits_out),
  .info_summary_out(info_summary_out));
